//--- core/gh_host.sv
`timescale 1ns/100ps
module gh_host
    import gh_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    gh_if.host                      bus,
    input  wire logic [7:0]         swAddr,
    input  wire logic [DATA_W-1:0]  swWdata,
    input  wire logic               swWr,
    input  wire logic               swRd,
    output logic [DATA_W-1:0]       swRdata
);
    typedef enum {H_IDLE, H_SETUP, H_WAIT, H_STROBE, H_CAPTURE} gh_state_e;

    gh_state_e           state_q;
    logic [DATA_W-1:0]   baseCfg_q;
    logic [DATA_W-1:0]   midCfg_q;
    logic                baseSeen_q;
    logic                midSeen_q;
    logic [ADDR_W-1:0]   accAddr_q;
    logic [DATA_W-1:0]   accData_q;
    logic                accRead_q;
    logic                accIo_q;
    logic [7:0]          hit_q;
    logic [1:0]          waitCnt_q;
    logic                ignRdy_q;
    logic                forceRdy_q;
    logic                upperLast_q;
    logic                noSelLast_q;
    logic [NUM_DEV-1:0]  csN_q;
    logic [1:0]          regSel_q;
    logic                wrN_q;
    logic                rdN_q;
    logic                upperN_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   swRdata_q;
    logic [7:0]          hitNow;
    logic                cfgOk;
    logic                extRdy;
    logic [DATA_W-1:0]   rdMux;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [7:0] decodeHit(
        input logic [ADDR_W-1:0] addr,
        input logic              io,
        input logic [DATA_W-1:0] baseCfg,
        input logic [DATA_W-1:0] midCfg,
        input logic              ok
    );
        logic [7:0] hit;
        logic [2:0] region;
        hit    = '0;
        region = addr[REGION_LSB+2:REGION_LSB];
        if (!io && addr[ADDR_W-1:BASE_LSB] == UPPER_BLOCK) begin
            hit[7] = 1'b1;
        end else if (ok && io == midCfg[MID_IO_BIT]
                     && addr[ADDR_W-1:BASE_LSB] == baseCfg[ADDR_W-1:BASE_LSB]
                     && region != 3'h7) begin
            hit[region] = 1'b1;
        end
        return hit;
    endfunction : decodeHit

    assign cfgOk  = baseSeen_q & midSeen_q;
    assign hitNow = decodeHit(accAddr_q, accIo_q, baseCfg_q, midCfg_q, cfgOk);
    assign extRdy = (&bus.devRdy) | forceRdy_q;

    // ------------------------------------------------------------
    // Select configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baseCfg_q <= CFG_RST;
            midCfg_q  <= CFG_RST;
        end else if (swWr && swAddr == OFF_BASE_CFG) begin
            baseCfg_q <= swWdata;
        end else if (swWr && swAddr == OFF_MID_CFG) begin
            midCfg_q <= swWdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baseSeen_q <= 1'b0;
            midSeen_q  <= 1'b0;
        end else begin
            if ((swWr || swRd) && swAddr == OFF_BASE_CFG) begin
                baseSeen_q <= 1'b1;
            end
            if ((swWr || swRd) && swAddr == OFF_MID_CFG) begin
                midSeen_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            forceRdy_q <= 1'b1;
        end else begin
            forceRdy_q <= ~(baseCfg_q[RDY_IGN_BIT] & midCfg_q[RDY_IGN_BIT]);
        end
    end

    // ------------------------------------------------------------
    // Access request registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accAddr_q <= '0;
            accData_q <= '0;
        end else begin
            if (swWr && swAddr == OFF_ACC_ADDR) begin
                accAddr_q <= swWdata[ADDR_W-1:0];
            end
            if (swWr && swAddr == OFF_ACC_DATA) begin
                accData_q <= swWdata;
            end else if (state_q == H_CAPTURE) begin
                accData_q <= bus.rdata[0] & {DATA_W{~csN_q[0]}}
                           | bus.rdata[1] & {DATA_W{~csN_q[1]}}
                           | bus.rdata[2] & {DATA_W{~csN_q[2]}}
                           | bus.rdata[3] & {DATA_W{~csN_q[3]}};
            end
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= H_IDLE;
            accRead_q   <= 1'b0;
            accIo_q     <= 1'b0;
            hit_q       <= '0;
            waitCnt_q   <= '0;
            ignRdy_q    <= 1'b0;
            upperLast_q <= 1'b0;
            noSelLast_q <= 1'b0;
        end else begin
            case (state_q)
                H_IDLE: begin
                    if (swWr && swAddr == OFF_ACC_CTRL && swWdata[CTRL_START_BIT]) begin
                        accRead_q <= swWdata[CTRL_READ_BIT];
                        accIo_q   <= swWdata[CTRL_IO_BIT];
                        state_q   <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    hit_q       <= hitNow;
                    upperLast_q <= hitNow[7];
                    noSelLast_q <= ~|hitNow;
                    if (hitNow[7]) begin
                        waitCnt_q <= UPPER_WAITS;
                        ignRdy_q  <= 1'b0;
                    end else if (|hitNow[3:0]) begin
                        waitCnt_q <= baseCfg_q[RDY_WAIT_LSB+1:RDY_WAIT_LSB];
                        ignRdy_q  <= baseCfg_q[RDY_IGN_BIT];
                    end else begin
                        waitCnt_q <= midCfg_q[RDY_WAIT_LSB+1:RDY_WAIT_LSB];
                        ignRdy_q  <= midCfg_q[RDY_IGN_BIT];
                    end
                    state_q <= (|hitNow) ? H_WAIT : H_IDLE;
                end
                H_WAIT: begin
                    if (waitCnt_q != 2'h0) begin
                        waitCnt_q <= waitCnt_q - 2'h1;
                    end else if (ignRdy_q || extRdy) begin
                        state_q <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    state_q <= accRead_q ? H_CAPTURE : H_IDLE;
                end
                H_CAPTURE: begin
                    state_q <= H_IDLE;
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bus pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            csN_q    <= '1;
            upperN_q <= 1'b1;
            regSel_q <= '0;
            wdata_q  <= '0;
        end else if (state_q == H_WAIT || state_q == H_STROBE) begin
            csN_q    <= ~(hit_q[NUM_DEV-1:0] | {NUM_DEV{hit_q[GROUP_SEL]}});
            upperN_q <= ~hit_q[7];
            regSel_q <= accAddr_q[REG_SEL_LSB+1:REG_SEL_LSB];
            wdata_q  <= accData_q;
        end else if (state_q != H_CAPTURE) begin
            csN_q    <= '1;
            upperN_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrN_q <= 1'b1;
            rdN_q <= 1'b1;
        end else begin
            wrN_q <= ~(state_q == H_WAIT && waitCnt_q == 2'h0
                       && (ignRdy_q || extRdy) && !accRead_q);
            rdN_q <= ~(state_q == H_WAIT && waitCnt_q == 2'h0
                       && (ignRdy_q || extRdy) && accRead_q);
        end
    end

    // ------------------------------------------------------------
    // Software read port
    // ------------------------------------------------------------
    always_comb begin
        case (swAddr)
            OFF_BASE_CFG: rdMux = baseCfg_q;
            OFF_MID_CFG:  rdMux = midCfg_q;
            OFF_ACC_ADDR: rdMux = accAddr_q;
            OFF_ACC_DATA: rdMux = accData_q;
            OFF_STATUS: begin
                rdMux = '0;
                rdMux[ST_BUSY_BIT]  = (state_q != H_IDLE);
                rdMux[ST_CFGOK_BIT] = cfgOk;
                rdMux[ST_UPPER_BIT] = upperLast_q;
                rdMux[ST_NOSEL_BIT] = noSelLast_q;
                rdMux[ST_IRQ_LSB+NUM_DEV-1:ST_IRQ_LSB] = ~bus.irqN;
            end
            default:      rdMux = '0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            swRdata_q <= '0;
        end else if (swRd) begin
            swRdata_q <= rdMux;
        end
    end

    assign bus.csN       = csN_q;
    assign bus.upperSelN = upperN_q;
    assign bus.regSel    = regSel_q;
    assign bus.wrN       = wrN_q;
    assign bus.rdN       = rdN_q;
    assign bus.wdata     = wdata_q;
    assign swRdata       = swRdata_q;
endmodule : gh_host

//--- core/gh_pkg.sv
package gh_pkg;
    // ------------------------------------------------------------
    // Bus shape
    // ------------------------------------------------------------
    localparam int NUM_DEV   = 4;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 16;
    localparam int NUM_SEL   = 7;
    localparam int GROUP_SEL = 4;
    localparam int INT_W     = 8;
    localparam int POS_W     = 2;

    // ------------------------------------------------------------
    // Graphics device ports (register select values)
    // ------------------------------------------------------------
    localparam logic [1:0] PORT_INSTR  = 2'h0;
    localparam logic [1:0] PORT_IACK   = 2'h1;
    localparam logic [1:0] PORT_IEN    = 2'h2;
    localparam logic [1:0] PORT_STATUS = 2'h3;
    localparam int         OP_LSB      = 8;
    localparam logic [7:0] OP_SET_POS  = 8'h5a;
    localparam logic [INT_W-1:0] IEN_RST = 8'h00;

    // ------------------------------------------------------------
    // Host address decode
    // ------------------------------------------------------------
    localparam int         REG_SEL_LSB  = 1;
    localparam int         REGION_LSB   = 7;
    localparam int         BASE_LSB     = 10;
    localparam logic [5:0] UPPER_BLOCK  = 6'h3f;
    localparam logic [1:0] UPPER_WAITS  = 2'h3;

    // ------------------------------------------------------------
    // Host software registers
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_BASE_CFG = 8'h00;
    localparam logic [7:0] OFF_MID_CFG  = 8'h04;
    localparam logic [7:0] OFF_ACC_ADDR = 8'h08;
    localparam logic [7:0] OFF_ACC_DATA = 8'h0c;
    localparam logic [7:0] OFF_ACC_CTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;

    localparam int RDY_WAIT_LSB = 0;
    localparam int RDY_IGN_BIT  = 2;
    localparam int MID_IO_BIT   = 7;
    localparam logic [DATA_W-1:0] CFG_RST = 16'h0003;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_READ_BIT  = 1;
    localparam int CTRL_IO_BIT    = 2;

    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_CFGOK_BIT = 1;
    localparam int ST_UPPER_BIT = 2;
    localparam int ST_NOSEL_BIT = 3;
    localparam int ST_IRQ_LSB   = 4;
endpackage : gh_pkg

//--- core/gh_if.sv
`timescale 1ns/100ps
interface gh_if;
    import gh_pkg::*;
    logic [NUM_DEV-1:0] csN;
    logic [1:0]         regSel;
    logic               wrN;
    logic               rdN;
    logic               upperSelN;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata [NUM_DEV];
    logic [NUM_DEV-1:0] irqN;
    logic [NUM_DEV-1:0] devRdy;

    modport host (
        output csN,
        output regSel,
        output wrN,
        output rdN,
        output upperSelN,
        output wdata,
        input  rdata,
        input  irqN,
        input  devRdy
    );

    modport dev (
        input  csN,
        input  regSel,
        input  wrN,
        input  rdN,
        input  wdata,
        output rdata,
        output irqN,
        output devRdy
    );
endinterface : gh_if

//--- core/gh_dev.sv
`timescale 1ns/100ps
module gh_dev
    import gh_pkg::*;
#(
    parameter int DEV_ID = 0
) (
    input  wire logic              clk,
    input  wire logic              rst,
    gh_if.dev                      bus,
    input  wire logic [INT_W-1:0]  intEvent,
    output logic                   instrValid,
    output logic [DATA_W-1:0]      instrWord,
    output logic [POS_W-1:0]       position
);
    logic                 sel;
    logic                 wrHit;
    logic                 rdHit;
    logic [INT_W-1:0]     pend_q;
    logic [INT_W-1:0]     ien_q;
    logic [POS_W-1:0]     pos_q;
    logic                 instrValid_q;
    logic [DATA_W-1:0]    instrWord_q;
    logic [DATA_W-1:0]    rdata_q;
    logic                 irqN_q;
    logic                 rdy_q;

    assign sel   = ~bus.csN[DEV_ID];
    assign wrHit = sel & ~bus.wrN;
    assign rdHit = sel & ~bus.rdN;

    // ------------------------------------------------------------
    // Instruction port and position
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instrValid_q <= 1'b0;
            instrWord_q  <= '0;
        end else begin
            instrValid_q <= wrHit && bus.regSel == PORT_INSTR;
            if (wrHit && bus.regSel == PORT_INSTR) begin
                instrWord_q <= bus.wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_q <= '0;
        end else if (wrHit && bus.regSel == PORT_INSTR
                     && bus.wdata[DATA_W-1:OP_LSB] == OP_SET_POS) begin
            pos_q <= bus.wdata[POS_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupt pending, enable and request
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
        end else if (wrHit && bus.regSel == PORT_IACK) begin
            pend_q <= (pend_q & ~bus.wdata[INT_W-1:0]) | intEvent;
        end else begin
            pend_q <= pend_q | intEvent;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ien_q <= IEN_RST;
        end else if (wrHit && bus.regSel == PORT_IEN) begin
            ien_q <= bus.wdata[INT_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqN_q <= 1'b1;
        end else begin
            irqN_q <= ~|(pend_q & ien_q);
        end
    end

    // ------------------------------------------------------------
    // Read data and ready
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (rdHit) begin
            case (bus.regSel)
                PORT_IACK:   rdata_q <= {{(DATA_W-INT_W){1'b0}}, pend_q};
                PORT_IEN:    rdata_q <= {{(DATA_W-INT_W){1'b0}}, ien_q};
                PORT_STATUS: rdata_q <= {{(DATA_W-POS_W){1'b0}}, pos_q};
                default:     rdata_q <= instrWord_q;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= 1'b1;
        end
    end

    assign bus.rdata[DEV_ID]  = rdata_q;
    assign bus.irqN[DEV_ID]   = irqN_q;
    assign bus.devRdy[DEV_ID] = rdy_q;
    assign instrValid         = instrValid_q;
    assign instrWord          = instrWord_q;
    assign position           = pos_q;
endmodule : gh_dev

//--- tb/gh_checker.sv
`timescale 1ns/100ps
module gh_checker
    import gh_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [NUM_DEV-1:0]  csN,
    input wire logic [1:0]          regSel,
    input wire logic                wrN,
    input wire logic                rdN,
    input wire logic                upperSelN,
    input wire logic [DATA_W-1:0]   wdata,
    input wire logic [DATA_W-1:0]   rdata [NUM_DEV],
    input wire logic [NUM_DEV-1:0]  irqN,
    input wire logic [NUM_DEV-1:0]  devRdy
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [NUM_DEV-1:0] ackW;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence selStart;
        $past(csN) == 4'hf && csN != 4'hf;
    endsequence

    sequence strobeLow;
        !wrN || !rdN;
    endsequence

    // ------------------------------------------------------------
    // Select, strobe and ready checks
    // ------------------------------------------------------------
    select_shape_a: assert property (csN == 4'h0 || $onehot0(~csN))
        else $error("device selects neither single nor group");
    group_hold_a: assert property (csN == 4'h0 |=> csN == 4'h0 || csN == 4'hf)
        else $error("group select split apart");
    strobe_select_a: assert property (strobeLow |-> csN != 4'hf || !upperSelN)
        else $error("strobe without any select");
    upper_alone_a: assert property (!upperSelN |-> csN == 4'hf)
        else $error("upper select overlaps device select");
    wait_bound_a: assert property (selStart |-> ##[0:12] strobeLow)
        else $error("strobe late after select");
    write_end_a: assert property (!wrN |=> wrN ##1 csN == 4'hf)
        else $error("write strobe or select not released");
    read_hold_a: assert property (!rdN |=> rdN && $stable(csN))
        else $error("select dropped in read capture cycle");
    reg_stable_a: assert property (csN != 4'hf && $past(csN) == csN
        |-> $stable(regSel) && $stable(wdata))
        else $error("register select moved inside access");
    ready_rise_a: assert property ($fell(rst) |=> &devRdy)
        else $error("device ready missing after reset");

    // ------------------------------------------------------------
    // Interrupt clear only by acknowledge or enable write
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_DEV; g++) begin : gIrq
        assign ackW[g] = !wrN && !csN[g] && (regSel == PORT_IACK || regSel == PORT_IEN);
        irq_clear_a: assert property ($rose(irqN[g]) |->
            $past(ackW[g]) || $past(ackW[g], 2) || $past(ackW[g], 3))
            else $error("interrupt released without acknowledge");
    end
endmodule : gh_checker

//--- tb/test_graphics_host_select_irq_glue.sv
`timescale 1ns/100ps
module test_graphics_host_select_irq_glue;
    import gh_pkg::*;
    logic                clk;
    logic                rst;
    logic [7:0]          swAddr;
    logic [DATA_W-1:0]   swWdata;
    logic                swWr;
    logic                swRd;
    logic [DATA_W-1:0]   swRdata;
    logic [INT_W-1:0]    intEvent [NUM_DEV];
    logic [NUM_DEV-1:0]  instrValid;
    logic [DATA_W-1:0]   instrWord [NUM_DEV];
    logic [POS_W-1:0]    position [NUM_DEV];
    logic [NUM_DEV-1:0]  lastIv = '0;
    logic [DATA_W-1:0]   v;
    logic [DATA_W-1:0]   st;
    int                  err_total;
    int                  compares;
    int                  cycles = 0;
    int                  csLow = 0;
    int                  upLow = 0;
    int                  c0;
    int                  lows [4];

    gh_if gh_if_inst ();
    gh_host gh_host_inst (.clk(clk), .rst(rst), .bus(gh_if_inst.host), .swAddr(swAddr),
        .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
    for (genvar g = 0; g < NUM_DEV; g++) begin : gDev
        gh_dev #(.DEV_ID(g)) gh_dev_inst (.clk(clk), .rst(rst), .bus(gh_if_inst.dev),
            .intEvent(intEvent[g]), .instrValid(instrValid[g]),
            .instrWord(instrWord[g]), .position(position[g]));
    end
    gh_checker gh_checker_inst (.clk(clk), .rst(rst), .csN(gh_if_inst.csN),
        .regSel(gh_if_inst.regSel), .wrN(gh_if_inst.wrN), .rdN(gh_if_inst.rdN),
        .upperSelN(gh_if_inst.upperSelN), .wdata(gh_if_inst.wdata),
        .rdata(gh_if_inst.rdata), .irqN(gh_if_inst.irqN), .devRdy(gh_if_inst.devRdy));

    // ------------------------------------------------------------
    // Clock, monitor and timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (gh_if_inst.csN[0] === 1'b0) csLow++;
        if (gh_if_inst.upperSelN === 1'b0) upLow++;
        if (instrValid != 4'h0) lastIv <= instrValid;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic swW(input logic [7:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        swAddr  <= a;
        swWdata <= d;
        swWr    <= 1'b1;
        @(posedge clk);
        swWr    <= 1'b0;
    endtask : swW

    task automatic swR(input logic [7:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        swAddr <= a;
        swRd   <= 1'b1;
        @(posedge clk);
        swRd   <= 1'b0;
        #1 d = swRdata;
    endtask : swR

    task automatic acc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic rd, input logic io);
        swW(OFF_ACC_ADDR, a);
        swW(OFF_ACC_DATA, d);
        swW(OFF_ACC_CTRL, {13'h0, io, rd, 1'b1});
        for (int i = 0; i < 50; i++) begin
            swR(OFF_STATUS, st);
            if (st[ST_BUSY_BIT] === 1'b0) break;
        end
        chk("busy", 16'h0, 16'(st[ST_BUSY_BIT]));
        if (rd) swR(OFF_ACC_DATA, v);
    endtask : acc

    function automatic logic [ADDR_W-1:0] dadr(input int n, input int p);
        return 16'h2000 + 16'(n * 128 + p * 2);
    endfunction : dadr

    task automatic pulse(input logic [INT_W-1:0] e);
        @(posedge clk);
        intEvent[1] <= e;
        @(posedge clk);
        intEvent[1] <= '0;
        repeat (4) @(posedge clk);
    endtask : pulse

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        swAddr = '0;
        swWdata = '0;
        swWr = 1'b0;
        swRd = 1'b0;
        err_total = 0;
        compares = 0;
        foreach (intEvent[i]) intEvent[i] = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1 chk("csN", 16'h000f, 16'(gh_if_inst.csN));
        chk("upperSelN", 16'h1, 16'(gh_if_inst.upperSelN));
        swR(OFF_BASE_CFG, v);
        chk("baseCfg", CFG_RST, v);
        acc(dadr(0, 0), {OP_SET_POS, 8'h03}, 1'b0, 1'b0);
        chk("noSel", 16'h1, 16'(st[ST_NOSEL_BIT]));
        chk("pos0", 16'h0, 16'(position[0]));
        acc(16'hfc00, 16'h0, 1'b1, 1'b0);
        chk("upperHit", 16'h1, 16'(st[ST_UPPER_BIT]));
        chk("upperWaits", 16'h1, 16'(upLow > int'(UPPER_WAITS)));
        swW(OFF_BASE_CFG, 16'h2005);
        swW(OFF_MID_CFG, 16'h0005);
        swR(OFF_MID_CFG, v);
        chk("midCfg", 16'h0005, v);
        swR(OFF_STATUS, v);
        chk("cfgOk", 16'h1, 16'(v[ST_CFGOK_BIT]));
        for (int n = 0; n < NUM_DEV; n++) begin
            acc(dadr(n, 0), {OP_SET_POS, 6'h0, 2'(3 - n)}, 1'b0, 1'b0);
        end
        chk("lastIv", 16'h0008, 16'(lastIv));
        for (int n = 0; n < NUM_DEV; n++) begin
            chk("position", 16'(3 - n), 16'(position[n]));
            acc(dadr(n, 3), 16'h0, 1'b1, 1'b0);
            chk("statusPort", 16'(3 - n), 16'(v[1:0]));
        end
        acc(dadr(GROUP_SEL, 0), 16'h1234, 1'b0, 1'b0);
        chk("groupIv", 16'h000f, 16'(lastIv));
        for (int n = 0; n < NUM_DEV; n++) chk("instrWord", 16'h1234, instrWord[n]);
        acc(dadr(1, 2), 16'h00ff, 1'b0, 1'b0);
        pulse(8'h05);
        chk("irqSet", 16'h0, 16'(gh_if_inst.irqN[1]));
        swR(OFF_STATUS, v);
        chk("irqStatus", 16'h1, 16'(v[ST_IRQ_LSB + 1]));
        acc(dadr(1, 1), 16'h0001, 1'b0, 1'b0);
        chk("irqPartial", 16'h0, 16'(gh_if_inst.irqN[1]));
        acc(dadr(1, 1), 16'h0, 1'b1, 1'b0);
        chk("pending", 16'h0004, 16'(v[7:0]));
        acc(dadr(1, 1), 16'h0004, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk("irqClear", 16'h1, 16'(gh_if_inst.irqN[1]));
        acc(dadr(1, 2), 16'h0001, 1'b0, 1'b0);
        pulse(8'h08);
        chk("irqMasked", 16'h1, 16'(gh_if_inst.irqN[1]));
        for (int w = 0; w < 4; w++) begin
            swW(OFF_BASE_CFG, 16'h2004 | 16'(w));
            c0 = csLow;
            acc(dadr(0, 3), 16'h0, 1'b1, 1'b0);
            lows[w] = csLow - c0;
            chk("waitStates", 16'(w), 16'(lows[w] - lows[0]));
        end
        swW(OFF_BASE_CFG, 16'h2001);
        acc(dadr(0, 3), 16'h0, 1'b1, 1'b0);
        chk("honourRead", 16'h0003, 16'(v[1:0]));
        swW(OFF_MID_CFG, 16'h0085);
        acc(dadr(2, 0), {OP_SET_POS, 8'h02}, 1'b0, 1'b0);
        chk("memMiss", 16'h1, 16'(st[ST_NOSEL_BIT]));
        chk("posKept", 16'h1, 16'(position[2]));
        acc(dadr(2, 0), {OP_SET_POS, 8'h02}, 1'b0, 1'b1);
        chk("ioHit", 16'h2, 16'(position[2]));
        test_done();
    end
endmodule : test_graphics_host_select_irq_glue
